// *** hw/dsc_defines.svh ***
/*
  Shared constants of the DDR burst-of-two SRAM link: timing figures, pipeline
  stages, register offsets and field positions of the controller.
  Assumes aclk at 125 MHz and inclusion by bare name from the SRAM end, controller end and bench files.
*/
// Operation
// - Accept commands only after lock wait
// - Bypass pin low skips loop locking
// - Clock stalled over 30 ns resets loop
// - Bypass pin rising edge resets loop
// - Early bypass release needs later loop reset
// - Frequency change needs loop reset, wait
// - Controller holds all inputs at levels
// - Second beat address is first plus one
// - New address only when load low
// - Load high is no-op, bus tri-stated
// - Select high with load starts read
// - Select low with load starts write
// - Read beats at t+2.5 and t+3.0
// - Write beats at t+5.0 and t+5.5
// - Finish pending commands before clock stop
// - Lock needs 2048 stable clock cycles
// - Bypassed loop gives one-cycle read latency
`ifndef DSC_DEFINES_SVH
`define DSC_DEFINES_SVH

`define DSC_CLK_NS      8
`define DSC_STOP_NS     30
`define DSC_STOP_CYC    ((`DSC_STOP_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_LOCK_WAIT   2048
`define DSC_K_HALF      2
`define DSC_RD_STAGE    2
`define DSC_BYP_STAGE   0
`define DSC_WR_STAGE    4

`define DSC_REG_CTRL    8'h00
`define DSC_REG_CMD     8'h04
`define DSC_REG_ADDR    8'h08
`define DSC_REG_WDATA0  8'h0C
`define DSC_REG_WDATA1  8'h10
`define DSC_REG_RDATA0  8'h14
`define DSC_REG_RDATA1  8'h18
`define DSC_REG_STATUS  8'h1C

`define DSC_CTRL_DOFF   0
`define DSC_CTRL_STOP   1
`define DSC_CMD_RD      0
`define DSC_STAT_BUSY   0
`define DSC_STAT_READY  1
`define DSC_STAT_PEND   2
`define DSC_CTRL_RST    2'h0

`define DSC_RESP_OKAY   2'h0
`define DSC_RESP_SLVERR 2'h2

`endif

// *** hw/dsc_pkg.sv ***
/*
  Types shared by both ends of the SRAM link.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package dsc_pkg;

  // Loop state of the memory end
  typedef enum logic [0:0] {loop_lock, loop_ready} dsc_loop_t;

  // Operation state of the controller end
  typedef enum logic [0:0] {op_idle, op_run} dsc_op_t;

endpackage

// *** hw/dsc_if.sv ***
/*
  Pin bundle between memory controller and DDR SRAM, one modport per end.
  Assumes both ends run on the same aclk; the shared data bus is resolved here.
*/
`timescale 1ns/100ps
interface dsc_if #(
  parameter int DW = 18,
  parameter int AW = 8
);
  logic          k;
  logic          k_n;
  logic          load_new_address_n;
  logic          rw;
  logic          doff_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] dq_c;
  logic          dq_oe_c;
  logic [DW-1:0] dq_s;
  logic          dq_oe_s;
  wire  [DW-1:0] dq;

  // Bus level from the two enables; a clash shows as memory data, an idle bus reads low
  assign dq = dq_oe_s ? dq_s : (dq_oe_c ? dq_c : {DW{1'b0}});

  modport sram (
    input  k,
    input  k_n,
    input  load_new_address_n,
    input  rw,
    input  doff_n,
    input  addr,
    input  dq,
    output dq_s,
    output dq_oe_s
  );

  modport ctrl (
    output k,
    output k_n,
    output load_new_address_n,
    output rw,
    output doff_n,
    output addr,
    output dq_c,
    output dq_oe_c,
    input  dq
  );
endinterface

// *** hw/dsc_array.sv ***
/*
  Storage array of the SRAM model: one write port, one combinational read port.
  Assumes the instantiating end registers the read data itself.
*/
`timescale 1ns/100ps
module dsc_array #(
  parameter int DW = 18,
  parameter int BW = 9
) (
  input  wire logic          aclk,
  input  wire logic          we,
  input  wire logic [BW-1:0] waddr,
  input  wire logic [DW-1:0] wdata,
  input  wire logic [BW-1:0] raddr,
  output logic      [DW-1:0] rdata
);
  logic [DW-1:0] mem [2**BW];

  // Contents are undefined after power-up, as in the real part
  always_ff @(posedge aclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  assign rdata = mem[raddr];
endmodule

// *** hw/dsc_sram.sv ***
/*
  Memory end of the DDR burst-of-two common-I/O SRAM link: loop lock and
  reset handling, command decode, burst pipeline and data bus drive.
  Assumes the link pins change right after aclk edges and that K and K#
  each hold for at least one aclk cycle between changes.
*/
`timescale 1ns/100ps
`include "dsc_defines.svh"
module dsc_sram
  import dsc_pkg::*;
#(
  parameter int DW        = 18,
  parameter int AW        = 8,
  parameter int LOCK_WAIT = `DSC_LOCK_WAIT
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  dsc_if.sram       link,
  output logic      ready,
  output logic      loop_bypassed
);
  localparam int STOP_CYC = `DSC_STOP_CYC;
  localparam int SW       = $clog2(STOP_CYC + 1);
  localparam int LW       = $clog2(LOCK_WAIT + 1);
  localparam int RD       = `DSC_RD_STAGE;
  localparam int BY       = `DSC_BYP_STAGE;
  localparam int WR       = `DSC_WR_STAGE;
  localparam int PD       = WR + 2;

  // Refuse shapes the bus and counters cannot serve
  generate
    if (LOCK_WAIT < 1 || DW < 1 || DW > 32 || AW < 1) begin : g_chk
      $error("dsc_sram: unsupported parameter values");
    end
  endgenerate

  // Burst beat address: beat one is the base plus one
  function automatic logic [AW:0] beat_addr(input logic [AW-1:0] a, input logic b);
    beat_addr = {a, b};
  endfunction

  logic          k_q;
  logic          kn_q;
  logic          doff_q;
  logic [SW-1:0] stall;
  logic [LW-1:0] lock_cnt;
  dsc_loop_t     st;
  dsc_loop_t     next_st;
  logic [PD-1:0] pv;
  logic [PD-1:0] prd;
  logic [AW-1:0] pa [PD];
  logic [DW-1:0] rdata;

  // Previous pin levels for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      k_q    <= 1'b0;
      kn_q   <= 1'b0;
      doff_q <= 1'b0;
    end else begin
      k_q    <= link.k;
      kn_q   <= link.k_n;
      doff_q <= link.doff_n;
    end
  end

  // Edge and level decode of the clock and bypass pins
  wire k_rise    = link.k & ~k_q;
  wire kn_rise   = link.k_n & ~kn_q;
  wire moved     = (link.k != k_q) | (link.k_n != kn_q);
  wire byp       = ~link.doff_n;
  wire stopped   = (stall == SW'(STOP_CYC));
  wire doff_rise = link.doff_n & ~doff_q;
  // A stall ends at the first moving edge, which already counts toward lock
  wire loop_rst  = doff_rise | (stopped & ~moved);

  // Counts aclk cycles with neither clock moving; saturates once stopped
  // stalled clock detect
  always_ff @(posedge aclk) begin
    if (!aresetn || moved) begin
      stall <= '0;
    end else if (!stopped) begin
      stall <= stall + 1'b1;
    end
  end

  // Stable K rises since the last loop reset
  // lock count
  always_ff @(posedge aclk) begin
    if (!aresetn || st != loop_lock || loop_rst) begin
      lock_cnt <= '0;
    end else if (k_rise) begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  wire lock_done = k_rise & (lock_cnt == LW'(LOCK_WAIT - 1));

  // Loop state; a stall held the whole time keeps the loop in reset
  always_comb begin
    next_st = st;
    case (st)
      loop_lock: begin
        if (byp) begin
          next_st = loop_ready;
        end else if (!loop_rst && lock_done) begin
          next_st = loop_ready;
        end
      end
      loop_ready: begin
        if (!byp && loop_rst) begin
          next_st = loop_lock;
        end
      end
      default: begin
        next_st = loop_lock;
      end
    endcase
  end

  // State and status flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st            <= loop_lock;
      ready         <= 1'b0;
      loop_bypassed <= 1'b0;
    end else begin
      st            <= next_st;
      ready         <= (next_st == loop_ready);
      loop_bypassed <= byp;
    end
  end

  // take only on load low
  // Commands seen before lock completes are dropped silently
  wire take = k_rise & (st == loop_ready) & ~link.load_new_address_n;

  // Command pipeline, one stage per K rise; stage 0 holds the newest
  // read when select high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pv[0]  <= 1'b0;
      prd[0] <= 1'b0;
      pa[0]  <= '0;
    end else if (k_rise) begin
      pv[0]  <= take;
      prd[0] <= link.rw;
      pa[0]  <= link.addr;
    end
  end

  generate
    for (genvar i = 1; i < PD; i++) begin : g_pipe
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          pv[i]  <= 1'b0;
          prd[i] <= 1'b0;
          pa[i]  <= '0;
        end else if (k_rise) begin
          pv[i]  <= pv[i-1];
          prd[i] <= prd[i-1];
          pa[i]  <= pa[i-1];
        end
      end
    end
  endgenerate

  // Read beat selection per clock edge; stage values are taken before
  // the shift, so a K rise sees the command that was one stage younger
  // beats at t+2.5, t+3.0
  wire rd_norm   = ~byp & pv[RD] & prd[RD];
  wire k_rd      = byp ? (pv[BY] & prd[BY]) : rd_norm;
  wire kn_rd     = byp ? (pv[BY+1] & prd[BY+1]) : rd_norm;
  wire [AW:0] k_ra  = byp ? beat_addr(pa[BY], 1'b0) : beat_addr(pa[RD], 1'b1);
  wire [AW:0] kn_ra = byp ? beat_addr(pa[BY+1], 1'b1) : beat_addr(pa[RD], 1'b0);
  wire rd_hit    = (k_rise & k_rd) | (kn_rise & kn_rd);
  wire [AW:0] ra = kn_rise ? kn_ra : k_ra;

  // Late write: beats taken from the bus five cycles after the command
  // sample at t+5.0, t+5.5
  wire k_wr      = k_rise & pv[WR] & ~prd[WR];
  wire kn_wr     = kn_rise & pv[WR+1] & ~prd[WR+1];
  wire [AW:0] wa = k_wr ? beat_addr(pa[WR], 1'b0) : beat_addr(pa[WR+1], 1'b1);

  // Writes land in the array directly; reads of the last two writes (last four with the loop bypassed)
  // still in flight return the older contents
  dsc_array #(
    .DW (DW),
    .BW (AW + 1)
  ) u_array (
    .aclk  (aclk),
    .we    (k_wr | kn_wr),
    .waddr (wa),
    .wdata (link.dq),
    .raddr (ra),
    .rdata (rdata)
  );

  // Data bus drive, updated only on clock edges
  // no read beat drops the memory output enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.dq_oe_s <= 1'b0;
      link.dq_s    <= '0;
    end else if (k_rise || kn_rise) begin
      link.dq_oe_s <= rd_hit;
      if (rd_hit) begin
        link.dq_s <= rdata;
      end
    end
  end
endmodule

// *** hw/dsc_ctrl.sv ***
/*
  Controller end of the SRAM link: K/K# generation, loop reset tracking and
  one-at-a-time burst commands, steered over an AXI4-Lite register slave.
  Assumes one software master and that the SRAM shares aclk.
*/
// Design decisions made here: the AXI4-Lite register port and the address map.
`timescale 1ns/100ps
`include "dsc_defines.svh"
module dsc_ctrl
  import dsc_pkg::*;
#(
  parameter int DW        = 18,
  parameter int AW        = 8,
  parameter int K_HALF    = `DSC_K_HALF,
  parameter int LOCK_WAIT = `DSC_LOCK_WAIT
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_awaddr,
  input  wire logic        s_awvalid,
  output logic             s_awready,
  input  wire logic [31:0] s_wdata,
  input  wire logic [3:0]  s_wstrb,
  input  wire logic        s_wvalid,
  output logic             s_wready,
  output logic [1:0]       s_bresp,
  output logic             s_bvalid,
  input  wire logic        s_bready,
  input  wire logic [7:0]  s_araddr,
  input  wire logic        s_arvalid,
  output logic             s_arready,
  output logic [31:0]      s_rdata,
  output logic [1:0]       s_rresp,
  output logic             s_rvalid,
  input  wire logic        s_rready,
  dsc_if.ctrl              link
);
  localparam int HW = $clog2(K_HALF + 1);
  localparam int LW = $clog2(LOCK_WAIT + 1);
  localparam int RD = `DSC_RD_STAGE;
  localparam int WR = `DSC_WR_STAGE;
  localparam int PW = $clog2(WR + 3);

  // Half periods must outlast the output flop but not look like a stall
  generate
    if (K_HALF < 2 || K_HALF > `DSC_STOP_CYC || DW > 32 || AW > 30 || LOCK_WAIT < 1) begin : g_chk
      $error("dsc_ctrl: unsupported parameter values");
    end
  endgenerate

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[8*b +: 8] = s[b] ? n[8*b +: 8] : o[8*b +: 8];
    end
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a <= `DSC_REG_STATUS);
  endfunction

  logic [HW-1:0] half;
  logic [LW-1:0] lock_cnt;
  logic [PW-1:0] ph;
  dsc_op_t       op;
  logic          ctrl_stop;
  logic          cmd_pend;
  logic          cmd_rw;
  logic          op_rd;
  logic          op_byp;
  logic [AW-1:0] cmd_addr;
  logic [DW-1:0] wd0;
  logic [DW-1:0] wd1;
  logic [DW-1:0] rd0;
  logic [DW-1:0] rd1;
  logic          aw_held;
  logic          w_held;
  logic [7:0]    aw_q;
  logic [31:0]   wd_q;
  logic [3:0]    ws_q;

  // Clock divider and edge plan; the clock only parks with K low
  // stop only when idle
  wire tick  = (half == HW'(K_HALF - 1));
  wire halt  = ctrl_stop & (op == op_idle) & ~cmd_pend & ~link.k;
  wire run   = tick & ~halt;
  wire k_up  = run & ~link.k;
  wire k_dn  = run & link.k;
  wire locked  = (lock_cnt == LW'(LOCK_WAIT));
  wire link_ok = ~link.doff_n | locked;
  wire issue   = (op == op_idle) & k_up & cmd_pend & link_ok;
  wire wr_done = ~op_rd & k_up & (ph == PW'(WR + 1));
  wire rd_done = op_rd & (op_byp ? (k_up & ph == PW'(1)) : (k_dn & ph == PW'(RD + 1)));
  wire done    = (op == op_run) & (wr_done | rd_done);

  // AXI write decode
  wire [7:0]  wo  = {aw_q[7:2], 2'b00};
  wire        do_wr = aw_held & w_held & ~s_bvalid;
  wire        aw_take = s_awvalid & s_awready;
  wire        w_take  = s_wvalid & s_wready;
  wire        next_aw_held = ~do_wr & (aw_held | aw_take);
  wire        next_w_held  = ~do_wr & (w_held | w_take);
  wire [31:0] v_ctrl = {30'h0000_0000, ctrl_stop, link.doff_n};
  wire [31:0] v_addr = 32'(cmd_addr);
  wire [31:0] v_wd0  = 32'(wd0);
  wire [31:0] v_wd1  = 32'(wd1);
  wire [31:0] v_stat = {29'h0000_0000, cmd_pend, link_ok, op == op_run};
  wire [31:0] m_ctrl = merge(v_ctrl, wd_q, ws_q);
  wire        doff_up = do_wr & (wo == `DSC_REG_CTRL) & m_ctrl[`DSC_CTRL_DOFF] & ~link.doff_n;

  // AXI read selection
  wire [7:0]  ro = {s_araddr[7:2], 2'b00};
  wire        next_rvalid = (s_rvalid & ~s_rready) | (s_arvalid & s_arready);
  wire [31:0] rd_mux = (ro == `DSC_REG_CTRL)   ? v_ctrl :
                       (ro == `DSC_REG_ADDR)   ? v_addr :
                       (ro == `DSC_REG_WDATA0) ? v_wd0  :
                       (ro == `DSC_REG_WDATA1) ? v_wd1  :
                       (ro == `DSC_REG_RDATA0) ? 32'(rd0) :
                       (ro == `DSC_REG_RDATA1) ? 32'(rd1) :
                       (ro == `DSC_REG_STATUS) ? v_stat : 32'h0000_0000;

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      s_awready <= 1'b0;
      s_wready  <= 1'b0;
      s_bvalid  <= 1'b0;
      s_bresp   <= `DSC_RESP_OKAY;
    end else begin
      aw_held   <= next_aw_held;
      w_held    <= next_w_held;
      s_awready <= ~next_aw_held;
      s_wready  <= ~next_w_held;
      if (aw_take) aw_q <= s_awaddr;
      if (w_take) begin
        wd_q <= s_wdata;
        ws_q <= s_wstrb;
      end
      if (do_wr) begin
        s_bvalid <= 1'b1;
        s_bresp  <= mapped(aw_q) ? `DSC_RESP_OKAY : `DSC_RESP_SLVERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // Read channel: one cycle from address to data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_arready <= 1'b0;
      s_rvalid  <= 1'b0;
      s_rdata   <= 32'h0000_0000;
      s_rresp   <= `DSC_RESP_OKAY;
    end else begin
      s_arready <= ~next_rvalid;
      s_rvalid  <= next_rvalid;
      if (s_arvalid && s_arready) begin
        s_rdata <= rd_mux;
        s_rresp <= mapped(s_araddr) ? `DSC_RESP_OKAY : `DSC_RESP_SLVERR;
      end
    end
  end

  // Software registers; a command write while one is pending is dropped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {ctrl_stop, link.doff_n} <= `DSC_CTRL_RST;
      cmd_pend <= 1'b0;
      cmd_rw   <= 1'b0;
      cmd_addr <= '0;
      wd0      <= '0;
      wd1      <= '0;
    end else begin
      if (issue) cmd_pend <= 1'b0;
      if (do_wr) begin
        case (wo)
          `DSC_REG_CTRL: {ctrl_stop, link.doff_n} <= {m_ctrl[`DSC_CTRL_STOP], m_ctrl[`DSC_CTRL_DOFF]};
          `DSC_REG_CMD: begin
            if (ws_q[0] && !cmd_pend && op == op_idle) begin
              cmd_pend <= 1'b1;
              cmd_rw   <= wd_q[`DSC_CMD_RD];
            end
          end
          `DSC_REG_ADDR:   cmd_addr <= AW'(merge(v_addr, wd_q, ws_q));
          `DSC_REG_WDATA0: wd0 <= DW'(merge(v_wd0, wd_q, ws_q));
          `DSC_REG_WDATA1: wd1 <= DW'(merge(v_wd1, wd_q, ws_q));
          default: begin
          end
        endcase
      end
    end
  end

  // K/K# generation, parked at defined levels from reset
  // pins always at levels
  always_ff @(posedge aclk) begin
    if (!aresetn || tick) begin
      half <= '0;
    end else begin
      half <= half + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.k   <= 1'b0;
      link.k_n <= 1'b1;
    end else if (run) begin
      link.k   <= ~link.k;
      link.k_n <= link.k;
    end
  end

  // Track the memory's relock after a bypass release or a clock park
  // reset loop after release
  always_ff @(posedge aclk) begin
    if (!aresetn || doff_up || (tick && halt)) begin
      lock_cnt <= '0;
    end else if (k_up && !locked) begin
      lock_cnt <= lock_cnt + 1'b1;
    end
  end

  // Operation sequencing, counted in generated K rises
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op <= op_idle;
      ph <= '0;
      op_rd  <= 1'b0;
      op_byp <= 1'b0;
      link.load_new_address_n <= 1'b1;
      link.rw   <= 1'b1;
      link.addr <= '0;
    end else begin
      case (op)
        op_idle: if (issue) op <= op_run;
        op_run:  if (done) op <= op_idle;
        default: op <= op_idle;
      endcase
      // load low for one K rise
      if (issue) begin
        link.load_new_address_n <= 1'b0;
        link.rw   <= cmd_rw;
        link.addr <= cmd_addr;
        op_rd  <= cmd_rw;
        op_byp <= ~link.doff_n;
        ph     <= '0;
      end else if (k_up) begin
        link.load_new_address_n <= 1'b1;
        if (op == op_run) ph <= ph + 1'b1;
      end
    end
  end

  // Write beats out and read beats in
  // drive at t+5.0, t+5.5
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.dq_c    <= '0;
      link.dq_oe_c <= 1'b0;
      rd0 <= '0;
      rd1 <= '0;
    end else if (op == op_run) begin
      if (!op_rd && k_up && ph == PW'(WR)) begin
        link.dq_c    <= wd0;
        link.dq_oe_c <= 1'b1;
      end
      if (!op_rd && k_dn && ph == PW'(WR + 1)) link.dq_c <= wd1;
      if (wr_done) link.dq_oe_c <= 1'b0;
      if (op_rd && (op_byp ? (k_dn && ph == PW'(1)) : (k_up && ph == PW'(RD)))) rd0 <= link.dq;
      if (rd_done) rd1 <= link.dq;
    end
  end
endmodule

// *** tb/dsc_link_monitor.sv ***
/*
  Concurrent checks on the pins between controller and SRAM ends.
  Assumes K_HALF of 2 aclk cycles and that both ends share aclk.
*/
`timescale 1ns/100ps
module dsc_link_monitor #(
  parameter int DW = 18
) (
  input wire logic          aclk,
  input wire logic          aresetn,
  input wire logic          k,
  input wire logic          k_n,
  input wire logic          load_new_address_n,
  input wire logic          rw,
  input wire logic          doff_n,
  input wire logic [DW-1:0] dq_s,
  input wire logic          dq_oe_s,
  input wire logic [DW-1:0] dq_c,
  input wire logic          dq_oe_c
);
  logic k_d;
  logic kn_d;
  logic k_rise;
  logic kn_rise;

  // Last clock levels mark the cycles in which the memory samples
  always_ff @(posedge aclk) begin
    k_d  <= k;
    kn_d <= k_n;
  end
  assign k_rise  = k & ~k_d;
  assign kn_rise = k_n & ~kn_d;

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_clk_compl: assert property (k_n == ~k)
    else $error("k_n is not the inverse of k");
  a_load_on_rise: assert property ($fell(load_new_address_n) |-> $rose(k))
    else $error("load strobe fell off a K rise");
  a_load_width: assert property ($fell(load_new_address_n) |-> load_new_address_n == 1'b0 [*4] ##1 load_new_address_n)
    else $error("load strobe not low for one K period");
  a_read_latency: assert property (($fell(load_new_address_n) && rw && doff_n) |-> !dq_oe_s [*8] ##[1:5] dq_oe_s)
    else $error("normal read beat not at t+2.5");
  a_bypass_latency: assert property (($fell(load_new_address_n) && rw && !doff_n) |-> !dq_oe_s [*2] ##[1:5] dq_oe_s)
    else $error("bypass read beat not at t+1");
  a_write_beat: assert property (($fell(load_new_address_n) && !rw) |-> !dq_oe_c [*8] ##[10:14] dq_oe_c)
    else $error("write data not driven at t+5");
  a_write_span: assert property ($rose(dq_oe_c) |-> dq_oe_c [*4] ##1 !dq_oe_c)
    else $error("write drive not one K period");
  a_wdata_driven: assert property ($changed(dq_c) |-> dq_oe_c)
    else $error("write data moved while not driven");
  a_no_clash: assert property (dq_oe_c |-> !dq_oe_s)
    else $error("memory drives during write data");
  a_oe_on_edge: assert property ($changed(dq_oe_s) |-> $past(k_rise || kn_rise))
    else $error("memory enable changed off a clock rise");
  a_stop_hold: assert property (($stable(k) && $stable(k_n)) |=> $stable(dq_s) && $stable(dq_oe_s))
    else $error("memory bus moved without a clock rise");

  // Main traffic kinds seen on the link
  c_read_normal: cover property ($fell(load_new_address_n) && rw && doff_n);
  c_read_bypass: cover property ($fell(load_new_address_n) && rw && !doff_n);
  c_write: cover property ($fell(load_new_address_n) && !rw);
endmodule

// *** tb/tb_top.sv ***
/*
  Bench for controller and SRAM ends joined by the link interface.
  Assumes register map of the controller defines; lock wait shortened to 8.
*/
`timescale 1ns/100ps
`include "dsc_defines.svh"
module tb_top;
  localparam int LOCK = 8;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, ready, loop_bypassed;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, rs;
  int          error_cnt, num_checks, cyc;

  dsc_if #(.DW(18), .AW(8)) u_dsc_if ();
  dsc_sram #(.DW(18), .AW(8), .LOCK_WAIT(LOCK)) u_dsc_sram (.aclk(aclk), .aresetn(aresetn), .link(u_dsc_if),
    .ready(ready), .loop_bypassed(loop_bypassed));
  dsc_ctrl #(.DW(18), .AW(8), .LOCK_WAIT(LOCK)) u_dsc_ctrl (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(awready), .s_wdata(wdata), .s_wstrb(wstrb),
    .s_wvalid(wvalid), .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
    .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata), .s_rresp(rresp),
    .s_rvalid(rvalid), .s_rready(rready), .link(u_dsc_if));
  dsc_link_monitor #(.DW(18)) u_dsc_link_monitor (.aclk(aclk), .aresetn(aresetn), .k(u_dsc_if.k),
    .k_n(u_dsc_if.k_n), .load_new_address_n(u_dsc_if.load_new_address_n), .rw(u_dsc_if.rw),
    .doff_n(u_dsc_if.doff_n), .dq_s(u_dsc_if.dq_s), .dq_oe_s(u_dsc_if.dq_oe_s), .dq_c(u_dsc_if.dq_c),
    .dq_oe_c(u_dsc_if.dq_oe_c));

  // Free-running bus clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("errors %0d checks %0d", error_cnt, num_checks);
    if (error_cnt == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Write one register; address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    rs = bresp;
    bready <= 1'b0;
  endtask

  // Read one register into rd and rs
  task automatic rd_reg(input logic [7:0] a);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rd = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  // One burst: write carries both beats, read leaves them in RDATA0/1
  task automatic op(input logic [7:0] a, input logic [31:0] w0, input logic [31:0] w1, input logic r);
    wr(`DSC_REG_ADDR, {24'h00_0000, a});
    if (!r) begin
      wr(`DSC_REG_WDATA0, w0);
      wr(`DSC_REG_WDATA1, w1);
    end
    wr(`DSC_REG_CMD, {31'h0000_0000, r});
    do rd_reg(`DSC_REG_STATUS); while (rd[`DSC_STAT_BUSY] | rd[`DSC_STAT_PEND]);
  endtask

  // Read back both beats of the last read burst
  task automatic chk_beats(input logic [31:0] e0, input logic [31:0] e1);
    rd_reg(`DSC_REG_RDATA0);
    chk(rd, e0);
    rd_reg(`DSC_REG_RDATA1);
    chk(rd, e1);
  endtask

  task automatic wait_ready();
    do rd_reg(`DSC_REG_STATUS); while (!rd[`DSC_STAT_READY]);
  endtask

  // Hang guard, far above the several hundred cycles the sequence needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      end_of_test();
    end
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0000_0000;
    wstrb = 4'hF;
    error_cnt = 0;
    num_checks = 0;
    cyc = 0;
    aresetn = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`DSC_REG_CTRL);
    chk(rd, 32'h0000_0000);
    chk({31'h0000_0000, loop_bypassed}, 32'h0000_0001);
    rd_reg(`DSC_REG_STATUS);
    chk(rd, 32'h0000_0002);
    // Bypassed loop: write two bursts, read one back
    op(8'h05, 32'h0001_2345, 32'h0002_A5A5, 1'b0);
    op(8'h06, 32'h0003_FFFF, 32'h0000_0000, 1'b0);
    op(8'h05, 32'h0000_0000, 32'h0000_0000, 1'b1);
    chk_beats(32'h0001_2345, 32'h0002_A5A5);
    // Releasing bypass restarts the lock wait
    wr(`DSC_REG_CTRL, 32'h0000_0001);
    rd_reg(`DSC_REG_STATUS);
    chk({31'h0000_0000, rd[`DSC_STAT_READY]}, 32'h0000_0000);
    chk({31'h0000_0000, ready}, 32'h0000_0000);
    wait_ready();
    op(8'h06, 32'h0000_0000, 32'h0000_0000, 1'b1);
    chk_beats(32'h0003_FFFF, 32'h0000_0000);
    chk({31'h0000_0000, ready}, 32'h0000_0001);
    op(8'h09, 32'h0002_0001, 32'h0001_0002, 1'b0);
    op(8'h09, 32'h0000_0000, 32'h0000_0000, 1'b1);
    chk_beats(32'h0002_0001, 32'h0001_0002);
    // Clock parked well past 30 ns drops lock
    wr(`DSC_REG_CTRL, 32'h0000_0003);
    repeat (8) @(posedge aclk);
    rd_reg(`DSC_REG_STATUS);
    chk({31'h0000_0000, rd[`DSC_STAT_READY]}, 32'h0000_0000);
    chk({31'h0000_0000, ready}, 32'h0000_0000);
    wr(`DSC_REG_CTRL, 32'h0000_0001);
    wait_ready();
    op(8'h05, 32'h0000_0000, 32'h0000_0000, 1'b1);
    chk_beats(32'h0001_2345, 32'h0002_A5A5);
    // Byte strobes keep the unselected bytes
    wr(`DSC_REG_WDATA0, 32'h0003_FFFF);
    wstrb <= 4'h2;
    wr(`DSC_REG_WDATA0, 32'h0000_0000);
    wstrb <= 4'hF;
    rd_reg(`DSC_REG_WDATA0);
    chk(rd, 32'h0003_00FF);
    // Unmapped offsets are refused
    wr(8'h20, 32'h0000_0001);
    chk_resp(rs, `DSC_RESP_SLVERR);
    rd_reg(8'h40);
    chk_resp(rs, `DSC_RESP_SLVERR);
    chk(rd, 32'h0000_0000);
    end_of_test();
  end
endmodule
